/* File: logic/fpc_map.svh */
// Register offsets, field positions, keys and reset values for the flash protection block
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FPC_OFS_CTRL        4'h0
`define FPC_OFS_OPTION      4'h4
`define FPC_OFS_STATUS      4'h8

// ----------------------------------------------------------------
// Control register fields and values
// ----------------------------------------------------------------
`define FPC_CTRL_RESET      3'h0
`define FPC_BIT_PROG        0
`define FPC_BIT_LATCH       1
`define FPC_BIT_OPTSEL      2
`define FPC_KEY_FIRST       8'h56
`define FPC_KEY_SECOND      8'hAE

// ----------------------------------------------------------------
// Option and status fields
// ----------------------------------------------------------------
`define FPC_BIT_READOUT     0
`define FPC_BIT_WRERASE     1
`define FPC_BIT_UNLOCKED    2
`define FPC_BIT_ERASING     3
`define FPC_BIT_REFUSED     4

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define FPC_RESP_OKAY       2'h0
`define FPC_RESP_SLVERR     2'h2

`endif

/* File: logic/fpc_pkg.sv */
// Types shared by the flash protection block
`default_nettype none

package fpc_pkg;

	// ----------------------------------------------------------------
	// State machines
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		FPC_KEY_LOCKED = 3'b001,
		FPC_KEY_FIRST  = 3'b010,
		FPC_KEY_OPEN   = 3'b100
	} fpc_key_e;

	typedef enum logic [1:0]
	{
		FPC_ER_IDLE  = 2'b01,
		FPC_ER_ERASE = 2'b10
	} fpc_erase_e;

	typedef logic [7:0] fpc_byte_t;

endpackage : fpc_pkg
`default_nettype wire

/* File: logic/fpc_key_unlock.sv */
// Two-key unlock sequencer for the flash program control register
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"

module fpc_key_unlock
(
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ce,
	// Key writes
	input  wire logic             key_wr,
	input  wire fpc_pkg::fpc_byte_t key_data,
	// Unlock state
	output logic                  unlocked,
	output logic                  next_unlocked
);
	import fpc_pkg::*;

	fpc_key_e state;
	fpc_key_e next_state;

	// ----------------------------------------------------------------
	// Key sequence
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		if (ce && key_wr)
		begin
			case (state)
				FPC_KEY_LOCKED:
					next_state = (key_data == `FPC_KEY_FIRST) ? FPC_KEY_FIRST : FPC_KEY_LOCKED; // [RULE_09]
				FPC_KEY_FIRST:
					// Any wrong byte drops back, no partial credit [RULE_11]
					next_state = (key_data == `FPC_KEY_SECOND) ? FPC_KEY_OPEN : FPC_KEY_LOCKED; // [RULE_09]
				FPC_KEY_OPEN:
					next_state = FPC_KEY_OPEN;
				default:
					next_state = FPC_KEY_LOCKED;
			endcase
		end
		next_unlocked = (next_state == FPC_KEY_OPEN);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state    <= FPC_KEY_LOCKED;
			unlocked <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			unlocked <= next_unlocked;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence first_key_s;
		state == FPC_KEY_LOCKED && ce && key_wr && key_data == `FPC_KEY_FIRST;
	endsequence
	sequence second_key_s;
		state == FPC_KEY_FIRST && ce && key_wr && key_data == `FPC_KEY_SECOND;
	endsequence

	// Bus writes land at least three cycles apart
	key_order_a: assert property (first_key_s ##[3:8] second_key_s |=> unlocked) // [RULE_09]
		else $error("two keys in order did not unlock");
	wrong_key_a: assert property ((state == FPC_KEY_FIRST && ce && key_wr && // [RULE_11]
		key_data != `FPC_KEY_SECOND) |=> state == FPC_KEY_LOCKED && !unlocked)
		else $error("wrong second key did not relock");

endmodule : fpc_key_unlock
`default_nettype wire

/* File: logic/fpc_flash_protect.sv */
// Flash readout and write/erase protection with program control over AXI4-Lite
// ----------------------------------------------------------------
// Summary of operation
// (RULE_01) Readout lock blocks program memory extraction and refuses flash writes.
// (RULE_02) Readout lock also blocks extraction of the data EEPROM.
// (RULE_03) Clearing readout lock mass-erases flash and EEPROM before reprogramming opens.
// (RULE_04) Readout lock is a dedicated bit in the option byte.
// (RULE_05) Write/erase lock blocks flash program and erase; EEPROM stays writable. Code blocks program only; clearing readout lock still mass-erases.
// (RULE_06) Write/erase lock, once set, can never be cleared. Code clears it at reset and reloads it from opt_init_wrerase.
// (RULE_07) Write/erase lock is its own option bit, independent of readout lock.
// (RULE_08) Control register is 8 bits, resets to 00h, bits 7..3 zero.
// (RULE_09) Keys 56h then AEh written to control register unlock programming control.
// (RULE_10) External programming tools send the two keys themselves before commands.
// (RULE_11) A wrong key relocks; control bits ignore writes until fully unlocked.
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"

module fpc_flash_protect
(
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// Option byte contents loaded at reset release
	input  wire logic        opt_init_readout,
	input  wire logic        opt_init_wrerase,
	// AXI4-Lite write
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Memory array handshakes
	input  wire logic        prog_done,
	input  wire logic        erase_done,
	// Permissions and commands to the arrays
	output logic             prog_ext_read_en,
	output logic             eeprom_ext_read_en,
	output logic             prog_write_en,
	output logic             eeprom_write_en,
	output logic             data_latch_en,
	output logic             program_pulse,
	output logic             mass_erase_req
);
	import fpc_pkg::*;

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	logic        aw_held, next_aw_held;
	logic        w_held, next_w_held;
	logic [3:0]  wr_addr, next_wr_addr;
	logic [7:0]  wr_byte, next_wr_byte;
	logic        wr_lane, next_wr_lane;
	logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        wr_go;

	// ----------------------------------------------------------------
	// Protection state
	// ----------------------------------------------------------------
	logic [2:0]  ctrl_bits, next_ctrl_bits;
	logic        readout, next_readout;
	logic        wrerase, next_wrerase;
	logic        refused, next_refused;
	logic        straps_taken, next_straps_taken;
	fpc_erase_e  er_state, next_er_state;
	logic        unlocked, next_unlocked;
	logic        key_wr;
	logic        next_program_pulse;
	logic        wr_ctrl, wr_opt, wr_stat;

	assign wr_go   = aw_held && w_held && !bvalid;
	assign wr_ctrl = wr_go && wr_lane && wr_addr == `FPC_OFS_CTRL;
	assign wr_opt  = wr_go && wr_lane && wr_addr == `FPC_OFS_OPTION;
	assign wr_stat = wr_go && wr_lane && wr_addr == `FPC_OFS_STATUS;
	// Locked control writes are key bytes, never control data [RULE_11]
	assign key_wr  = wr_ctrl && !unlocked;

	fpc_key_unlock u_key
	(
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.key_wr        (key_wr),
		.key_data      (wr_byte),
		.unlocked      (unlocked),
		.next_unlocked (next_unlocked)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_wr_addr = wr_addr;
		next_wr_byte = wr_byte;
		next_wr_lane = wr_lane;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (awvalid && awready)
		begin
			next_aw_held = 1'b1;
			next_wr_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_w_held  = 1'b1;
			next_wr_byte = wdata[7:0];
			next_wr_lane = wstrb[0];
		end
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (wr_go)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wr_addr == `FPC_OFS_CTRL || wr_addr == `FPC_OFS_OPTION ||
				wr_addr == `FPC_OFS_STATUS) ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
		end
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `FPC_RESP_OKAY;
			case (araddr)
				`FPC_OFS_CTRL:   next_rdata = {29'h0, ctrl_bits}; // [RULE_08]
				`FPC_OFS_OPTION: next_rdata = {30'h0, wrerase, readout};
				`FPC_OFS_STATUS: next_rdata = {27'h0, refused, er_state == FPC_ER_ERASE,
					unlocked, wrerase, readout};
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = `FPC_RESP_SLVERR;
				end
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= 4'h0;
			wr_byte <= 8'h00;
			wr_lane <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `FPC_RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `FPC_RESP_OKAY;
		end
		else if (ce)
		begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			wr_addr <= next_wr_addr;
			wr_byte <= next_wr_byte;
			wr_lane <= next_wr_lane;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// Option byte, control bits and mass erase
	// ----------------------------------------------------------------
	always_comb
	begin
		next_ctrl_bits     = ctrl_bits;
		next_readout       = readout;
		next_wrerase       = wrerase;
		next_refused       = refused;
		next_er_state      = er_state;
		next_straps_taken  = 1'b1;
		next_program_pulse = 1'b0;
		// Straps caught on the first clock after release, never by the reset itself
		if (!straps_taken)
		begin
			next_readout = opt_init_readout;
			next_wrerase = opt_init_wrerase;
		end
		if (wr_stat && wr_byte[`FPC_BIT_REFUSED])
			next_refused = 1'b0;
		if (wr_ctrl && unlocked)
		begin
			next_ctrl_bits[`FPC_BIT_OPTSEL] = wr_byte[`FPC_BIT_OPTSEL];
			next_ctrl_bits[`FPC_BIT_LATCH]  = wr_byte[`FPC_BIT_LATCH];
			if (wr_byte[`FPC_BIT_PROG] && !wr_byte[`FPC_BIT_OPTSEL])
			begin
				if (readout || wrerase || er_state == FPC_ER_ERASE) // [RULE_01] [RULE_05]
					next_refused = 1'b1;
				else
				begin
					next_ctrl_bits[`FPC_BIT_PROG] = 1'b1;
					next_program_pulse            = 1'b1;
				end
			end
		end
		if (ctrl_bits[`FPC_BIT_PROG] && prog_done && !next_program_pulse)
			next_ctrl_bits[`FPC_BIT_PROG] = 1'b0;
		// Option byte is only reachable through the unlocked option select
		if (wr_opt)
		begin
			if (!unlocked || !ctrl_bits[`FPC_BIT_OPTSEL] || er_state == FPC_ER_ERASE)
				next_refused = 1'b1;
			else
			begin
				// Lock bit only ever ORs in here; only reset and the strap reload clear it [RULE_06] [RULE_07]
				next_wrerase = wrerase | wr_byte[`FPC_BIT_WRERASE];
				if (wr_byte[`FPC_BIT_READOUT])
					next_readout = 1'b1; // [RULE_04]
				else if (readout)
					next_er_state = FPC_ER_ERASE; // [RULE_03]
			end
		end
		case (er_state)
			FPC_ER_IDLE: ;
			FPC_ER_ERASE:
				if (erase_done)
				begin
					// Lock drops only after both arrays report erased [RULE_03]
					next_readout  = 1'b0;
					next_er_state = FPC_ER_IDLE;
				end
			default: next_er_state = FPC_ER_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_bits          <= `FPC_CTRL_RESET; // [RULE_08]
			readout            <= 1'b1;
			wrerase            <= 1'b0;
			refused            <= 1'b0;
			straps_taken       <= 1'b0;
			er_state           <= FPC_ER_IDLE;
			prog_ext_read_en   <= 1'b0;
			eeprom_ext_read_en <= 1'b0;
			prog_write_en      <= 1'b0;
			eeprom_write_en    <= 1'b0;
			data_latch_en      <= 1'b0;
			program_pulse      <= 1'b0;
			mass_erase_req     <= 1'b0;
		end
		else if (ce)
		begin
			ctrl_bits          <= next_ctrl_bits;
			readout            <= next_readout;
			wrerase            <= next_wrerase;
			refused            <= next_refused;
			straps_taken       <= next_straps_taken;
			er_state           <= next_er_state;
			prog_ext_read_en   <= !next_readout; // [RULE_01]
			eeprom_ext_read_en <= !next_readout; // [RULE_02]
			prog_write_en      <= next_unlocked && !next_readout && !next_wrerase && // [RULE_05]
				next_er_state == FPC_ER_IDLE;
			eeprom_write_en    <= next_unlocked && next_er_state == FPC_ER_IDLE; // [RULE_05]
			data_latch_en      <= next_ctrl_bits[`FPC_BIT_LATCH];
			program_pulse      <= next_program_pulse;
			mass_erase_req     <= next_er_state == FPC_ER_ERASE;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	ro_read_a: assert property (readout |-> !prog_ext_read_en && !program_pulse) // [RULE_01]
		else $error("program memory readable or programmed under readout lock");
	ro_write_a: assert property (readout |-> !prog_write_en) // [RULE_01]
		else $error("flash write enabled under readout lock");
	ro_eeprom_a: assert property (readout |-> !eeprom_ext_read_en) // [RULE_02]
		else $error("eeprom readable under readout lock");
	erase_first_a: assert property ($fell(readout) && $past(straps_taken) |-> // [RULE_03]
		$past(mass_erase_req) && $past(erase_done) && mass_erase_req == 1'b0)
		else $error("readout lock cleared without mass erase");
	opt_set_a: assert property ((ce && wr_opt && unlocked && ctrl_bits[`FPC_BIT_OPTSEL] && // [RULE_04]
		er_state == FPC_ER_IDLE && wr_byte[`FPC_BIT_READOUT]) |=> readout)
		else $error("option write failed to set readout lock");
	we_block_a: assert property (wrerase |-> !prog_write_en && !program_pulse) // [RULE_05]
		else $error("flash write enabled under write/erase lock");
	we_eeprom_a: assert property ((wrerase && unlocked && !mass_erase_req && straps_taken && // [RULE_05]
		!$past(mass_erase_req)) |-> eeprom_write_en)
		else $error("eeprom write blocked by write/erase lock");
	we_sticky_a: assert property (wrerase && straps_taken |=> wrerase) // [RULE_06]
		else $error("write/erase lock was cleared");
	we_indep_a: assert property ((ce && wr_opt && unlocked && ctrl_bits[`FPC_BIT_OPTSEL] && // [RULE_07]
		er_state == FPC_ER_IDLE && wr_byte[`FPC_BIT_WRERASE] &&
		wr_byte[`FPC_BIT_READOUT] == readout) |=> wrerase && readout == $past(readout))
		else $error("write/erase bit not independent of readout bit");
	ctrl_reset_a: assert property (disable iff (1'b0) !$past(aresetn) |-> ctrl_bits == 3'h0) // [RULE_08]
		else $error("control register not zero after reset");
	locked_ign_a: assert property ((wr_ctrl && !unlocked) |=> ctrl_bits == $past(ctrl_bits)) // [RULE_11]
		else $error("control bits changed while locked");

endmodule : fpc_flash_protect
`default_nettype wire

/* File: verif/fpc_array_model.sv */
// Behavioural flash and EEPROM arrays answering program and erase requests
`timescale 1ns/100ps
`default_nettype none

module fpc_array_model
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Answer speed
	input  wire logic slow,
	// Requests from the block
	input  wire logic program_pulse,
	input  wire logic mass_erase_req,
	// Answers to the block
	output logic      prog_done,
	output logic      erase_done
);
	// ----------------------------------------------------------------
	// Completion timers
	// ----------------------------------------------------------------
	int prog_cnt;
	int erase_cnt;

	// Done strobes last one cycle; the block samples them as levels on that clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prog_cnt   <= 0;
			erase_cnt  <= 0;
			prog_done  <= 1'b0;
			erase_done <= 1'b0;
		end
		else
		begin
			prog_done  <= 1'b0;
			erase_done <= 1'b0;
			if (program_pulse)
				prog_cnt <= slow ? 20 : 1;
			else if (prog_cnt != 0)
			begin
				prog_done <= (prog_cnt == 1);
				prog_cnt  <= prog_cnt - 1;
			end
			// Both arrays wiped before the request is answered
			if (erase_cnt != 0)
			begin
				erase_done <= (erase_cnt == 1);
				erase_cnt  <= erase_cnt - 1;
			end
			else if (mass_erase_req && !erase_done)
				erase_cnt <= slow ? 30 : 1;
		end
	end
endmodule : fpc_array_model
`default_nettype wire

/* File: verif/fpc_flash_protect_test.sv */
// Self-checking bench for the flash protection block
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"

module fpc_flash_protect_test;
	import fpc_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        aclk, aresetn, ce, opt_init_readout, opt_init_wrerase, slow;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, val;
	logic [1:0]  bresp, rresp, resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, prog_done, erase_done;
	logic        prog_ext_read_en, eeprom_ext_read_en, prog_write_en, eeprom_write_en;
	logic        data_latch_en, program_pulse, mass_erase_req;
	int          errors, n_tests, pulses, cyc;

	fpc_flash_protect DUT
	(
		.aclk(aclk), .aresetn(aresetn), .ce(ce), .opt_init_readout(opt_init_readout),
		.opt_init_wrerase(opt_init_wrerase), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .prog_done(prog_done), .erase_done(erase_done),
		.prog_ext_read_en(prog_ext_read_en), .eeprom_ext_read_en(eeprom_ext_read_en),
		.prog_write_en(prog_write_en), .eeprom_write_en(eeprom_write_en),
		.data_latch_en(data_latch_en), .program_pulse(program_pulse),
		.mass_erase_req(mass_erase_req)
	);

	fpc_array_model arrays
	(
		.aclk(aclk), .aresetn(aresetn), .slow(slow), .program_pulse(program_pulse),
		.mass_erase_req(mass_erase_req), .prog_done(prog_done), .erase_done(erase_done)
	);

	// ----------------------------------------------------------------
	// Clock, watchdog, pulse counter
	// ----------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc++;
		if (program_pulse === 1'b1)
			pulses++;
		if (cyc == 5000)
		begin
			errors++;
			$display("CHECK FAILED at %0t: run hung", $time);
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (pa && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (bvalid === 1'b1)
			begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [3:0] a);
		logic pa;
		pa = 1'b1;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (pa && arready === 1'b1)
			begin
				arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (rvalid === 1'b1)
			begin
				val = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, e, input string w);
		rd(a);
		check(val & m, e, w);
	endtask : rd_chk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_keys();
		rd_chk(`FPC_OFS_CTRL, 32'hFFFF_FFFF, 0, "ctrl reset");
		rd_chk(`FPC_OFS_STATUS, 32'hF, 32'h1, "status reset");
		check(prog_ext_read_en, 0, "flash readable");
		check(eeprom_ext_read_en, 0, "eeprom readable");
		wr(`FPC_OFS_CTRL, 8'h07);
		rd_chk(`FPC_OFS_CTRL, 32'hFF, 0, "locked ctrl");
		wr(`FPC_OFS_CTRL, `FPC_KEY_FIRST);
		wr(`FPC_OFS_CTRL, 8'h12);
		wr(`FPC_OFS_CTRL, `FPC_KEY_SECOND);
		rd_chk(`FPC_OFS_STATUS, 32'h4, 0, "broken key order");
		wr(`FPC_OFS_CTRL, `FPC_KEY_FIRST);
		wr(`FPC_OFS_CTRL, `FPC_KEY_SECOND);
		rd_chk(`FPC_OFS_STATUS, 32'h4, 32'h4, "unlocked");
		check(eeprom_write_en, 1, "eeprom writable");
		$display("test keys done");
	endtask : t_keys

	task automatic t_readout();
		wr(`FPC_OFS_CTRL, 8'h01);
		idle(3);
		check(pulses, 0, "program under readout lock");
		check(prog_write_en, 0, "flash write under readout lock");
		rd_chk(`FPC_OFS_STATUS, 32'h10, 32'h10, "refused flag");
		wr(`FPC_OFS_STATUS, 8'h10);
		rd_chk(`FPC_OFS_STATUS, 32'h10, 0, "flag cleared");
		$display("test readout done");
	endtask : t_readout

	task automatic t_erase();
		int n;
		n = 0;
		slow <= 1'b1;
		wr(`FPC_OFS_CTRL, 8'h04);
		wr(`FPC_OFS_OPTION, 8'h00);
		check(mass_erase_req, 1, "erase request");
		check(prog_write_en, 0, "flash write during erase");
		rd_chk(`FPC_OFS_STATUS, 32'hF, 32'hD, "erasing, still locked");
		while (mass_erase_req !== 1'b0 && n < 100)
		begin
			@(posedge aclk);
			n++;
		end
		idle(2);
		check(mass_erase_req, 0, "erase ended");
		check(prog_ext_read_en, 1, "flash readable");
		check(eeprom_ext_read_en, 1, "eeprom readable");
		rd_chk(`FPC_OFS_STATUS, 32'hF, 32'h4, "readout lock off");
		$display("test erase done");
	endtask : t_erase

	task automatic t_program();
		slow <= 1'b0;
		wr(`FPC_OFS_CTRL, 8'hFA);
		rd_chk(`FPC_OFS_CTRL, 32'hFFFF_FFFF, 32'h2, "upper bits zero");
		check(data_latch_en, 1, "latch");
		check(prog_write_en, 1, "flash writable");
		wr(`FPC_OFS_CTRL, 8'h03);
		idle(4);
		check(pulses, 1, "program start");
		rd_chk(`FPC_OFS_CTRL, 32'hFF, 32'h2, "start cleared by done");
		$display("test program done");
	endtask : t_program

	task automatic t_wrlock();
		wr(`FPC_OFS_CTRL, 8'h04);
		wr(`FPC_OFS_OPTION, 8'h02);
		check(prog_write_en, 0, "flash write under wr lock");
		check(eeprom_write_en, 1, "eeprom write under wr lock");
		rd_chk(`FPC_OFS_STATUS, 32'hF, 32'h6, "wr lock alone");
		wr(`FPC_OFS_OPTION, 8'h00);
		rd_chk(`FPC_OFS_STATUS, 32'h2, 32'h2, "wr lock kept");
		wr(`FPC_OFS_CTRL, 8'h01);
		idle(4);
		check(pulses, 1, "program under wr lock");
		wr(`FPC_OFS_CTRL, 8'h04);
		wr(`FPC_OFS_OPTION, 8'h01);
		idle(2);
		check(prog_ext_read_en, 0, "readout lock again");
		rd_chk(`FPC_OFS_STATUS, 32'h3, 32'h3, "both locks");
		wr(4'hC, 8'h55);
		check(resp, `FPC_RESP_SLVERR, "unmapped write");
		rd(4'hC);
		check(resp, `FPC_RESP_SLVERR, "unmapped read");
		$display("test wrlock done");
	endtask : t_wrlock

	task automatic t_straps();
		aresetn          <= 1'b0;
		opt_init_readout <= 1'b0;
		opt_init_wrerase <= 1'b1;
		idle(3);
		aresetn <= 1'b1;
		idle(3);
		rd_chk(`FPC_OFS_STATUS, 32'h1F, 32'h2, "straps after reset");
		check(prog_ext_read_en, 1, "flash readable without lock");
		check(prog_write_en, 0, "flash write under strap lock");
		check(eeprom_write_en, 0, "relocked by reset");
		$display("test straps done");
	endtask : t_straps

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		aresetn = 1'b0;
		ce = 1'b1;
		opt_init_readout = 1'b1;
		opt_init_wrerase = 1'b0;
		slow = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wstrb = 4'hF;
		wdata = 32'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		idle(2);
		t_keys();
		t_readout();
		t_erase();
		t_program();
		t_wrlock();
		t_straps();
		finish_test();
	end
endmodule : fpc_flash_protect_test
`default_nettype wire
